// File: rtl/p1g_defs.svh
// Purpose: Constants for the five-pin port register block
// Assumes: Register indices scaled by four give APB byte addresses
// Notes:   Definitions only
`ifndef P1G_DEFS_SVH
`define P1G_DEFS_SVH

// ---------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------
`define P1G_IDX_LATCH    16'hffd4
`define P1G_IDX_DIR      16'hffe4
`define P1G_IDX_PULLUP   16'hffed
`define P1G_IDX_FSEL     16'hfffc
`define P1G_ADDR_LATCH   {`P1G_IDX_LATCH, 2'b00}
`define P1G_ADDR_DIR     {`P1G_IDX_DIR, 2'b00}
`define P1G_ADDR_PULLUP  {`P1G_IDX_PULLUP, 2'b00}
`define P1G_ADDR_FSEL    {`P1G_IDX_FSEL, 2'b00}

// ---------------------------------------------
// Field masks and reset values
// ---------------------------------------------
`define P1G_PIN_MASK     8'hf1
`define P1G_ALT_IN_MASK  8'he0
`define P1G_ALT_OUT_MASK 8'h11
`define P1G_LATCH_RST    8'h00
`define P1G_DIR_RST      8'h00
`define P1G_PULLUP_RST   8'h00
`define P1G_FSEL_RST     8'h04
`define P1G_FSEL_FIXED   8'h04
`define P1G_DIR_READ     8'hff
`define P1G_SYNC_STAGES  2

`endif

// File: rtl/p1g_pkg.sv
// Purpose: Types shared by the port register block
// Assumes: Constants live in p1g_defs.svh
// Notes:   Types only
package p1g_pkg;

	typedef logic [7:0]  p1g_byte_t;
	typedef logic [17:0] p1g_addr_t;
	typedef logic [31:0] p1g_word_t;

	typedef enum logic [2:0] {
		P1G_REG_NONE   = 3'b000,
		P1G_REG_LATCH  = 3'b001,
		P1G_REG_DIR    = 3'b010,
		P1G_REG_PULLUP = 3'b011,
		P1G_REG_FSEL   = 3'b100
	} p1g_reg_e;

endpackage : p1g_pkg

// File: rtl/p1g_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module p1g_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : p1g_sync

// File: rtl/p1g_port.sv
// Purpose: Five-pin general I/O bank with APB register access
// Assumes: One clock, asynchronous active-high reset, zero-wait APB
// Notes:   Pins 7,6,5,4,0 exist; bits 3..1 are holes in every register
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "p1g_defs.svh"

// Overview of operation
// - The output latch holds one bit per pin 7,6,5,4,0 and drives output pins.
// - Latch bits 3 to 1 read as zero and ignore writes.
// - A port read of an output pin returns its latch bit, not the pin.
// - A port read of an input pin returns the synchronised pin level, two clocks old.
// - Reset clears the output latch.
// - A direction bit of 1 makes the pin an output driving its latch bit.
// - A direction bit of 0 makes the pin an input with the driver released.
// - Direction and latch act only while the pin is selected as general I/O.
// - The direction register is write-only and reads as all ones.
// - Reset clears the direction register so every pin starts as input.
// - On an input pin the pull-up bit switches the internal pull-up on or off.
// - Function select resets to 0x04, bit 2 reads one, bits 3 and 1 read zero.
// - A function-select bit of 0 gives general I/O, 1 the alternate function.
module p1g_port (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire p1g_pkg::p1g_addr_t paddr,
	input  wire p1g_pkg::p1g_word_t pwdata,
	output logic               pready,
	output p1g_pkg::p1g_word_t prdata,
	output logic               pslverr,
	input  wire p1g_pkg::p1g_byte_t pin_in,
	output p1g_pkg::p1g_byte_t pin_out,
	output p1g_pkg::p1g_byte_t pin_oe,
	output p1g_pkg::p1g_byte_t pin_pullup_en,
	input  wire logic          pwm_output_value,
	input  wire logic          timer_clock_output_value,
	output logic               ext_irq_three_select,
	output logic               ext_irq_two_select,
	output logic               ext_irq_one_select,
	output logic               pwm_output_select,
	output logic               timer_clock_output_select,
	output logic               ext_irq_three_level,
	output logic               ext_irq_two_level,
	output logic               ext_irq_one_level,
	output logic               timer_trigger_input
);
	import p1g_pkg::*;

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	p1g_byte_t latch_q;
	p1g_byte_t latch_d;
	p1g_byte_t dir_q;
	p1g_byte_t dir_d;
	p1g_byte_t pullup_q;
	p1g_byte_t pullup_d;
	p1g_byte_t fsel_q;
	p1g_byte_t fsel_d;
	p1g_word_t rdata_q;
	p1g_word_t rdata_d;
	logic      err_q;
	logic      err_d;
	p1g_byte_t pin_sync;

	// ---------------------------------------------
	// Pin synchroniser
	// ---------------------------------------------
	// Raw pins would let a read see a metastable level
	p1g_sync #(
		.WIDTH    (8)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// ---------------------------------------------
	// Address decode
	// ---------------------------------------------
	p1g_reg_e  reg_sel;
	wire logic hit_latch  = paddr == `P1G_ADDR_LATCH;
	wire logic hit_dir    = paddr == `P1G_ADDR_DIR;
	wire logic hit_pullup = paddr == `P1G_ADDR_PULLUP;
	wire logic hit_fsel   = paddr == `P1G_ADDR_FSEL;
	wire logic mapped     = hit_latch | hit_dir | hit_pullup | hit_fsel;
	wire logic setup_ph   = psel & ~penable;
	wire logic access_ph  = psel & penable;
	wire logic wr_en      = access_ph & pwrite & mapped;

	assign reg_sel = hit_latch  ? P1G_REG_LATCH  :
	                 hit_dir    ? P1G_REG_DIR    :
	                 hit_pullup ? P1G_REG_PULLUP :
	                 hit_fsel   ? P1G_REG_FSEL   : P1G_REG_NONE;

	// ---------------------------------------------
	// Pin function mapping
	// ---------------------------------------------
	wire p1g_byte_t gpio_mask = ~fsel_q & `P1G_PIN_MASK;
	wire p1g_byte_t alt_out_mask = fsel_q & `P1G_ALT_OUT_MASK;
	wire p1g_byte_t alt_out_val = {3'b000, pwm_output_value,
	                               3'b000, timer_clock_output_value};
	wire p1g_byte_t gpio_oe = dir_q & gpio_mask;

	assign pin_oe  = gpio_oe | alt_out_mask;
	assign pin_out = (latch_q & gpio_oe) | (alt_out_val & alt_out_mask);
	// Pull-up only makes sense while nothing drives the pin
	assign pin_pullup_en = pullup_q & ~pin_oe & `P1G_PIN_MASK;

	assign ext_irq_three_select      = fsel_q[7];
	assign ext_irq_two_select        = fsel_q[6];
	assign ext_irq_one_select        = fsel_q[5];
	assign pwm_output_select         = fsel_q[4];
	assign timer_clock_output_select = fsel_q[0];
	assign ext_irq_three_level       = pin_sync[7] & fsel_q[7];
	assign ext_irq_two_level         = pin_sync[6] & fsel_q[6];
	assign ext_irq_one_level         = pin_sync[5] & fsel_q[5];
	assign timer_trigger_input       = pin_sync[7] & fsel_q[7];

	// ---------------------------------------------
	// Read path
	// ---------------------------------------------
	// Output pins echo the latch, input pins the synchronised level
	wire p1g_byte_t port_view = ((latch_q & dir_q) |
	                             (pin_sync & ~dir_q)) & `P1G_PIN_MASK;

	p1g_byte_t rd_byte;
	always_comb begin
		case (reg_sel)
			P1G_REG_LATCH:  rd_byte = port_view;
			P1G_REG_DIR:    rd_byte = `P1G_DIR_READ;
			P1G_REG_PULLUP: rd_byte = pullup_q;
			P1G_REG_FSEL:   rd_byte = fsel_q;
			default:        rd_byte = 8'h00;
		endcase
	end

	// Read data captured in setup so it is stable all access phase
	assign rdata_d = setup_ph ? {24'h000000, rd_byte} : rdata_q;
	assign err_d   = setup_ph ? ~mapped : err_q;

	// ---------------------------------------------
	// Register writes
	// ---------------------------------------------
	wire p1g_byte_t wbyte = pwdata[7:0];
	assign latch_d  = (wr_en & hit_latch)  ? (wbyte & `P1G_PIN_MASK) : latch_q;
	assign dir_d    = (wr_en & hit_dir)    ? (wbyte & `P1G_PIN_MASK) : dir_q;
	assign pullup_d = (wr_en & hit_pullup) ? (wbyte & `P1G_PIN_MASK) : pullup_q;
	assign fsel_d   = (wr_en & hit_fsel)   ?
	                  ((wbyte & `P1G_PIN_MASK) | `P1G_FSEL_FIXED) : fsel_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			latch_q  <= `P1G_LATCH_RST;
			dir_q    <= `P1G_DIR_RST;
			pullup_q <= `P1G_PULLUP_RST;
			fsel_q   <= `P1G_FSEL_RST;
		end else begin
			latch_q  <= latch_d;
			dir_q    <= dir_d;
			pullup_q <= pullup_d;
			fsel_q   <= fsel_d;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// Zero wait: every access completes in its first access cycle
	assign pready  = access_ph;
	assign prdata  = access_ph ? rdata_q : 32'h00000000;
	assign pslverr = access_ph & err_q;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_rd_setup(logic hit);
		setup_ph && !pwrite && hit;
	endsequence

	sequence s_wr_access(logic hit);
		access_ph && pwrite && hit;
	endsequence

	a_latch_holes_zero: assert property (
		latch_q[3:1] == 3'b000
	) else $error("Latch reserved bits not zero");

	a_out_read_latch: assert property (
		s_rd_setup(hit_latch) |=>
		(prdata[7:0] & $past(dir_q)) == ($past(latch_q) & $past(dir_q))
	) else $error("Output pin read did not return latch");

	a_in_read_pin: assert property (
		s_rd_setup(hit_latch) ##0 (!$past(reset) && !$past(reset, 2)) |=>
		(prdata[7:0] & ~$past(dir_q)) ==
		($past(pin_in, 3) & ~$past(dir_q) & `P1G_PIN_MASK)
	) else $error("Input pin read did not return pin level");

	a_reset_clears: assert property (
		$fell(reset) |-> latch_q == 8'h00 && dir_q == 8'h00 && pin_oe == 8'h00
	) else $error("Reset values wrong");

	a_dir_write_oe: assert property (
		s_wr_access(hit_dir) ##0 (fsel_q == `P1G_FSEL_RST) |=>
		pin_oe == ($past(pwdata[7:0]) & `P1G_PIN_MASK)
	) else $error("Direction write did not steer drivers");

	a_input_released: assert property (
		(pin_oe & ~dir_q & ~fsel_q) == 8'h00
	) else $error("Input pin is driven");

	a_out_drives_latch: assert property (
		((pin_out ^ latch_q) & gpio_oe) == 8'h00
	) else $error("Output pin not driving latch");

	a_alt_ignores_gpio: assert property (
		(pin_oe & fsel_q & `P1G_ALT_IN_MASK) == 8'h00
	) else $error("Alternate input pin is driven");

	a_dir_reads_ones: assert property (
		s_rd_setup(hit_dir) |=> pready && prdata == 32'h000000ff
	) else $error("Direction read not all ones");

	a_pullup_input: assert property (
		(pin_pullup_en & pin_oe) == 8'h00
	) else $error("Pull-up on a driven pin");

	a_fsel_fixed_bits: assert property (
		s_rd_setup(hit_fsel) |=> prdata[3:1] == 3'b010
	) else $error("Function select reserved bits wrong");

	a_unmapped_err: assert property (
		setup_ph && !mapped ##1 access_ph |-> pslverr && pready
	) else $error("Unmapped access not flagged");

	a_write_at_end: assert property (
		s_wr_access(hit_latch) |-> ##1 latch_q == ($past(pwdata[7:0]) & `P1G_PIN_MASK)
	) else $error("Latch write not applied");

	a_write_dir_end: assert property (
		s_wr_access(hit_dir) |=> dir_q == ($past(pwdata[7:0]) & `P1G_PIN_MASK)
	) else $error("Direction write not applied");

	a_write_pullup_end: assert property (
		s_wr_access(hit_pullup) |=> pullup_q == ($past(pwdata[7:0]) & `P1G_PIN_MASK)
	) else $error("Pull-up write not applied");

	// ---------------------------------------------
	// Assertions: bus framing and reserved bits
	// ---------------------------------------------
	// Error and ready belong to one access cycle only
	sequence s_mapped_access;
		setup_ph && mapped ##1 access_ph;
	endsequence

	sequence s_unmapped_access;
		setup_ph && !mapped ##1 access_ph;
	endsequence

	a_idle_bus_quiet: assert property (
		!access_ph |-> !pready && !pslverr && prdata == 32'h00000000
	) else $error("Bus outputs active outside access");

	a_mapped_no_err: assert property (
		s_mapped_access |-> pready && !pslverr
	) else $error("Mapped access flagged as error");

	a_unmapped_no_write: assert property (
		s_unmapped_access ##0 pwrite |=>
		$stable(latch_q) && $stable(dir_q) && $stable(pullup_q) && $stable(fsel_q)
	) else $error("Unmapped write changed a register");

	a_unmapped_rd_zero: assert property (
		s_unmapped_access ##0 !pwrite |-> prdata == 32'h00000000
	) else $error("Unmapped read returned data");

	a_latch_read_holes: assert property (
		s_rd_setup(hit_latch) |=> prdata[3:1] == 3'b000
	) else $error("Port read reserved bits not zero");

	a_pullup_read_back: assert property (
		s_rd_setup(hit_pullup) |=> prdata == {24'h000000, $past(pullup_q)}
	) else $error("Pull-up read does not match register");

	a_fsel_write_end: assert property (
		s_wr_access(hit_fsel) |=>
		fsel_q == (($past(pwdata[7:0]) & `P1G_PIN_MASK) | `P1G_FSEL_FIXED)
	) else $error("Function select write not applied");

	a_reset_fsel_pullup: assert property (
		$fell(reset) |-> fsel_q == `P1G_FSEL_RST && pullup_q == `P1G_PULLUP_RST
	) else $error("Function select or pull-up reset value wrong");

	a_reset_pins_quiet: assert property (
		$fell(reset) |-> pin_out == 8'h00 && pin_pullup_en == 8'h00
	) else $error("Pins active after reset");

	// ---------------------------------------------
	// Assertions: pins and alternate functions
	// ---------------------------------------------
	// Pins hand over to the alternate function regardless of direction
	a_gpio_out_value: assert property (
		((pin_out ^ latch_q) & dir_q & ~fsel_q & `P1G_PIN_MASK) == 8'h00
	) else $error("General output pin not driving latch");

	a_undriven_low: assert property (
		(pin_out & ~pin_oe) == 8'h00
	) else $error("Value shown on an undriven pin");

	a_alt_out_driven: assert property (
		(fsel_q & ~pin_oe & `P1G_ALT_OUT_MASK) == 8'h00
	) else $error("Alternate output pin not driven");

	a_alt_out_value: assert property (
		fsel_q[4] |-> pin_out[4] == pwm_output_value
	) else $error("Pulse output pin shows wrong value");

	a_alt_clk_value: assert property (
		fsel_q[0] |-> pin_out[0] == timer_clock_output_value
	) else $error("Clock output pin shows wrong value");

	a_pullup_on_input: assert property (
		(pullup_q & ~dir_q & ~fsel_q & `P1G_PIN_MASK & ~pin_pullup_en) == 8'h00
	) else $error("Pull-up missing on an input pin");

	a_pullup_off_clear: assert property (
		(pin_pullup_en & ~pullup_q) == 8'h00
	) else $error("Pull-up on without its enable bit");

	a_select_follows: assert property (
		{ext_irq_three_select, ext_irq_two_select, ext_irq_one_select, pwm_output_select,
		 timer_clock_output_select} == {fsel_q[7:4], fsel_q[0]}
	) else $error("Select outputs differ from register");

	a_level_gated: assert property (
		({ext_irq_three_level, ext_irq_two_level, ext_irq_one_level, timer_trigger_input} &
		 ~{fsel_q[7:5], fsel_q[7]}) == 4'h0
	) else $error("Level output active without selection");

	// Guard skips edges where reset has just cleared the synchroniser
	a_level_two_flops: assert property (
		fsel_q[7] && !$past(reset) && !$past(reset, 2) |->
		ext_irq_three_level == $past(pin_in[7], 2)
	) else $error("Interrupt level not two flops behind pin");

endmodule : p1g_port

// File: test/p1g_board.sv
// Purpose: Board circuitry on the five port pins
// Assumes: Undriven pins without pull-up float
// Notes:   Floating pins toggle every cycle so a stale level cannot pass
`timescale 1ns/1ps
module p1g_board (
	input  wire logic               clk,
	input  wire p1g_pkg::p1g_byte_t pin_out,
	input  wire p1g_pkg::p1g_byte_t pin_oe,
	input  wire p1g_pkg::p1g_byte_t pin_pullup_en,
	input  wire p1g_pkg::p1g_byte_t drv_val,
	input  wire p1g_pkg::p1g_byte_t drv_en,
	input  wire logic               contend,
	output p1g_pkg::p1g_byte_t      pin_in
);
	import p1g_pkg::*;
	p1g_byte_t float_q = 8'h5a;
	always_ff @(posedge clk) float_q <= ~float_q;
	// Contend models an overloaded pin that the board pulls to its own level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = (pin_oe[i] && !(contend && drv_en[i])) ? pin_out[i] :
				drv_en[i] ? drv_val[i] : pin_pullup_en[i] ? 1'b1 : float_q[i];
		end
	end
endmodule : p1g_board

// File: test/testbench.sv
// Purpose: Self-checking bench for the port register block
// Assumes: APB slave answers within 20 cycles, two-flop pin synchroniser
// Notes:   One task per scenario
`timescale 1ns/1ps
`include "p1g_defs.svh"
module testbench;
	import p1g_pkg::*;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, contend = 0, pwm_v = 0, tmo_v = 0;
	logic pready, pslverr, s3, s2, s1, s4, s0, l3, l2, l1, trg, err;
	p1g_addr_t paddr = '0;
	p1g_word_t pwdata = '0, prdata, rd;
	p1g_byte_t pin_in, pin_out, pin_oe, pin_pu, drv_val = '0, drv_en = '0;
	int mismatches = 0, n_tests = 0;
	initial forever #5 clk = ~clk;
	p1g_port i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
		.pwm_output_value(pwm_v), .timer_clock_output_value(tmo_v), .ext_irq_three_select(s3),
		.ext_irq_two_select(s2), .ext_irq_one_select(s1), .pwm_output_select(s4),
		.timer_clock_output_select(s0), .ext_irq_three_level(l3), .ext_irq_two_level(l2),
		.ext_irq_one_level(l1), .timer_trigger_input(trg));
	p1g_board i_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
		.drv_val(drv_val), .drv_en(drv_en), .contend(contend), .pin_in(pin_in));
	// ---------------------------------------------
	// Bus and compare helpers
	// ---------------------------------------------
	task automatic report_and_stop;
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic chk(input p1g_word_t got, input p1g_word_t exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input p1g_addr_t a, input p1g_word_t wd);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Slave latency is not assumed; bounded wait for pready
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			mismatches++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input p1g_addr_t a, input p1g_word_t exp);
		apb(0, a, '0);
		chk(rd, exp);
		chk(err, 0);
	endtask : rchk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_reset;
		rchk(`P1G_ADDR_DIR, 32'h0000_00ff);
		chk(pin_oe, 8'h00);
		rchk(`P1G_ADDR_PULLUP, 32'h0000_0000);
		rchk(`P1G_ADDR_FSEL, 32'h0000_0004);
		// Input pins float, so the latch is seen only through outputs
		apb(1, `P1G_ADDR_DIR, 32'h0000_00ff);
		rchk(`P1G_ADDR_LATCH, 32'h0000_0000);
	endtask : t_reset
	task automatic t_rereset;
		apb(1, `P1G_ADDR_LATCH, 32'h0000_00ff);
		apb(1, `P1G_ADDR_PULLUP, 32'h0000_00ff);
		apb(1, `P1G_ADDR_FSEL, 32'h0000_00ff);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		chk(pin_oe, 8'h00);
		chk(pin_pu, 8'h00);
		chk(s4, 1'b0);
		rchk(`P1G_ADDR_FSEL, 32'h0000_0004);
		rchk(`P1G_ADDR_PULLUP, 32'h0000_0000);
		apb(1, `P1G_ADDR_DIR, 32'h0000_00ff);
		rchk(`P1G_ADDR_LATCH, 32'h0000_0000);
	endtask : t_rereset
	task automatic t_outputs;
		apb(1, `P1G_ADDR_DIR, 32'h0000_00ff);
		apb(1, `P1G_ADDR_LATCH, 32'hffff_ffff);
		settle(1);
		chk(pin_oe, 8'hf1);
		chk(pin_out, 8'hf1);
		rchk(`P1G_ADDR_LATCH, 32'h0000_00f1);
		rchk(`P1G_ADDR_DIR, 32'h0000_00ff);
		drv_en <= 8'hff; drv_val <= 8'h00; contend <= 1;
		settle(4);
		rchk(`P1G_ADDR_LATCH, 32'h0000_00f1);
		apb(1, `P1G_ADDR_DIR, 32'h0000_0011);
		settle(4);
		chk(pin_oe, 8'h11);
		rchk(`P1G_ADDR_LATCH, 32'h0000_0011);
		contend <= 0; drv_en <= 8'h00;
	endtask : t_outputs
	task automatic t_pullup;
		apb(1, `P1G_ADDR_PULLUP, 32'h0000_00ff);
		rchk(`P1G_ADDR_PULLUP, 32'h0000_00f1);
		settle(4);
		chk(pin_pu, 8'he0);
		rchk(`P1G_ADDR_LATCH, 32'h0000_00f1);
		apb(1, `P1G_ADDR_PULLUP, 32'h0);
		settle(1);
		chk(pin_pu, 8'h00);
	endtask : t_pullup
	task automatic t_altfn;
		apb(1, `P1G_ADDR_LATCH, 32'h0);
		pwm_v <= 1; tmo_v <= 0; drv_en <= 8'he0; drv_val <= 8'ha0;
		apb(1, `P1G_ADDR_FSEL, 32'h0000_00ff);
		rchk(`P1G_ADDR_FSEL, 32'h0000_00f5);
		settle(3);
		chk({s3, s2, s1, s4, s0}, 5'h1f);
		chk(pin_oe, 8'h11);
		chk(pin_out & 8'h11, 8'h10);
		chk({l3, l2, l1, trg}, 4'hb);
		@(posedge clk);
		pwm_v <= 1'b0;
		tmo_v <= 1'b1;
		settle(1);
		chk(pin_out & 8'h11, 8'h01);
		apb(1, `P1G_ADDR_FSEL, 32'h0);
		rchk(`P1G_ADDR_FSEL, 32'h0000_0004);
		settle(1);
		chk(pin_out & 8'h11, 8'h00);
	endtask : t_altfn
	task automatic t_unmapped;
		apb(1, 18'h00000, 32'hffff_ffff);
		chk(err, 1);
		apb(0, 18'h3ff54, '0);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		rchk(`P1G_ADDR_LATCH, 32'h0000_00a0);
	endtask : t_unmapped
	task automatic t_sync;
		drv_val <= 8'h00;
		rchk(`P1G_ADDR_LATCH, 32'h0000_00a0);
		settle(3);
		rchk(`P1G_ADDR_LATCH, 32'h0);
	endtask : t_sync
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		t_reset();
		t_outputs();
		t_pullup();
		t_altfn();
		t_unmapped();
		t_sync();
		t_rereset();
		report_and_stop();
	end
endmodule : testbench
